// ---- hw/usbc_defs.vh ----
// Shared constants of the control endpoint responder.
`ifndef USBC_DEFS_VH
`define USBC_DEFS_VH
// Register byte offsets on the AXI4-Lite bus.
`define USBC_OFF_MODE 6'h00
`define USBC_OFF_COUNT 6'h04
`define USBC_OFF_DATA_LO 6'h08
`define USBC_OFF_DATA_HI 6'h0C
// Mode register fields.
`define USBC_MODE_MSB 3
`define USBC_FLAG_ACK 4
`define USBC_FLAG_OUT 5
`define USBC_FLAG_IN 6
`define USBC_FLAG_SETUP 7
// Count register fields.
`define USBC_CNT_MSB 3
`define USBC_CNT_DVAL 6
`define USBC_CNT_TOG 7
// Reset values.
`define USBC_MODE_RST 8'h00
`define USBC_COUNT_RST 8'h00
// Mode encodings.
`define USBC_M_OFF 4'h0
`define USBC_M_NAK_IO 4'h1
`define USBC_M_STAT_OUT 4'h2
`define USBC_M_STALL_IO 4'h3
`define USBC_M_STAT_IN 4'h6
`define USBC_M_ACKO_STI 4'hB
`define USBC_M_ACKI_STO 4'hF
// Token kinds.
`define USBC_TOK_SETUP 2'h0
`define USBC_TOK_IN 2'h1
`define USBC_TOK_OUT 2'h2
// Handshake answer codes.
`define USBC_R_ACK 2'h0
`define USBC_R_NAK 2'h1
`define USBC_R_STALL 2'h2
`define USBC_R_TX 2'h3
// Packet length limits, data plus two CRC bytes, and the data buffer size in bytes.
`define USBC_LEN_MAX 4'hA
`define USBC_LEN_STATUS 4'h2
`define USBC_BUF_BYTES 4'h8
`endif

// ---- hw/usbc_fifo.v ----
// Small flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module usbc_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter AW = 2
) (
  // Clock and reset.
  input wire sys_clk_i,
  input wire reset_i,
  // Fill side.
  input wire [W-1:0] in_data_i,
  input wire in_valid_i,
  output wire in_ready_o,
  // Drain side.
  output wire [W-1:0] out_data_o,
  output wire out_valid_o,
  input wire out_ready_i
);
  reg [W-1:0] mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  reg rdy_r;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;
  wire [AW:0] cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  assign in_ready_o = rdy_r;
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o = mem_r[rp_r];

  // Pointers wrap naturally because the depth is a power of two.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
      rdy_r <= 1'b1;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data_i;
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      rdy_r <= (cnt_nxt != D[AW:0]);
    end
  end
endmodule

// ---- hw/usbc_axil.v ----
// AXI4-Lite slave front end that turns bus traffic into register strobes.
`timescale 1ns/1ps
`include "usbc_defs.vh"
module usbc_axil (
  // Clock and reset.
  input wire sys_clk_i,
  input wire reset_i,
  // Write address and data channels.
  input wire [5:0] axi_awaddr_i,
  input wire axi_awvalid_i,
  output reg axi_awready_o,
  input wire [31:0] axi_wdata_i,
  input wire [3:0] axi_wstrb_i,
  input wire axi_wvalid_i,
  output reg axi_wready_o,
  // Write response channel.
  output reg [1:0] axi_bresp_o,
  output reg axi_bvalid_o,
  input wire axi_bready_i,
  // Read channels.
  input wire [5:0] axi_araddr_i,
  input wire axi_arvalid_i,
  output reg axi_arready_o,
  output reg [31:0] axi_rdata_o,
  output reg [1:0] axi_rresp_o,
  output reg axi_rvalid_o,
  input wire axi_rready_i,
  // Register side.
  output wire wr_en_o,
  output wire [5:0] wr_addr_o,
  output wire [31:0] wr_data_o,
  output wire [3:0] wr_strb_o,
  output wire [5:0] rd_addr_o,
  input wire [31:0] rd_data_i
);
  reg [5:0] waddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_got_r;
  reg w_got_r;
  reg [5:0] raddr_r;
  reg rpend_r;

  // Only four aligned words are mapped; anything else answers SLVERR.
  function hit;
    input [5:0] a;
    begin
      hit = (a[1:0] == 2'h0) && (a <= `USBC_OFF_DATA_HI);
    end
  endfunction

  assign wr_en_o = aw_got_r & w_got_r & ~axi_bvalid_o & hit(waddr_r);
  assign wr_addr_o = waddr_r;
  assign wr_data_o = wdata_r;
  assign wr_strb_o = wstrb_r;
  assign rd_addr_o = raddr_r;

  // Address and data are taken independently, the response follows both.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      axi_awready_o <= 1'b0;
      axi_wready_o <= 1'b0;
      axi_bvalid_o <= 1'b0;
      axi_bresp_o <= 2'h0;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      waddr_r <= 6'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      axi_awready_o <= ~aw_got_r & ~(axi_awvalid_i & axi_awready_o);
      axi_wready_o <= ~w_got_r & ~(axi_wvalid_i & axi_wready_o);
      if (axi_awvalid_i & axi_awready_o) begin
        aw_got_r <= 1'b1;
        waddr_r <= axi_awaddr_i;
      end
      if (axi_wvalid_i & axi_wready_o) begin
        w_got_r <= 1'b1;
        wdata_r <= axi_wdata_i;
        wstrb_r <= axi_wstrb_i;
      end
      if (aw_got_r & w_got_r & ~axi_bvalid_o) begin
        axi_bvalid_o <= 1'b1;
        axi_bresp_o <= hit(waddr_r) ? 2'h0 : 2'h2;
      end else if (axi_bvalid_o & axi_bready_i) begin
        axi_bvalid_o <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end

  // Reads take one cycle to latch the address and one to return data.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      axi_arready_o <= 1'b0;
      axi_rvalid_o <= 1'b0;
      axi_rdata_o <= 32'h00000000;
      axi_rresp_o <= 2'h0;
      raddr_r <= 6'h00;
      rpend_r <= 1'b0;
    end else begin
      axi_arready_o <= ~rpend_r & ~axi_rvalid_o & ~(axi_arvalid_i & axi_arready_o);
      if (axi_arvalid_i & axi_arready_o) begin
        raddr_r <= axi_araddr_i;
        rpend_r <= 1'b1;
      end
      if (rpend_r) begin
        rpend_r <= 1'b0;
        axi_rvalid_o <= 1'b1;
        axi_rdata_o <= hit(raddr_r) ? rd_data_i : 32'h00000000;
        axi_rresp_o <= hit(raddr_r) ? 2'h0 : 2'h2;
      end else if (axi_rvalid_o & axi_rready_i) begin
        axi_rvalid_o <= 1'b0;
      end
    end
  end
endmodule

// ---- hw/usbc_ep0_responder.v ----
// Control endpoint zero token responder with its mode, count and data registers.
`timescale 1ns/1ps
`include "usbc_defs.vh"
// Contract
// - The four-bit mode field picks how each token is answered.
// - Stall-all mode ACKs a valid short SETUP and moves to mode 0001.
// - Every enabled mode drops bad SETUPs and accepts good ones alike.
// - Stall-all mode stalls IN and valid OUT, no mode change, no interrupt.
// - Mode 0001 accepts SETUP and NAKs IN and valid OUT.
// - Counted transmission sends the byte count held in the count register.
// - Mode 1111 OUT with bad length or toggle 0 stalls, mode 0011.
// - Mode 1111 OUT length 2 toggle 1 is ACKed, mode 0010.
// - Mode 0010 stalls IN, moves to mode 0011 and interrupts.
// - Status check ACKs only zero-data OUT carrying toggle 1.
// - A failed status check stalls or is ignored, never ACKed.
// - Status modes serve the status stage, IN or OUT token.
// - Endpoint off mode ignores all traffic to the endpoint.
module usbc_ep0_responder (
  // Clock and reset.
  input wire sys_clk_i,
  input wire reset_i,
  // AXI4-Lite register bus.
  input wire [5:0] axi_awaddr_i,
  input wire axi_awvalid_i,
  output wire axi_awready_o,
  input wire [31:0] axi_wdata_i,
  input wire [3:0] axi_wstrb_i,
  input wire axi_wvalid_i,
  output wire axi_wready_o,
  output wire [1:0] axi_bresp_o,
  output wire axi_bvalid_o,
  input wire axi_bready_i,
  input wire [5:0] axi_araddr_i,
  input wire axi_arvalid_i,
  output wire axi_arready_o,
  output wire [31:0] axi_rdata_o,
  output wire [1:0] axi_rresp_o,
  output wire axi_rvalid_o,
  input wire axi_rready_i,
  // Received data bytes from the packet decoder.
  input wire [7:0] rx_byte_i,
  input wire rx_valid_i,
  output wire rx_ready_o,
  // End of a token and its data packet.
  input wire tok_done_i,
  input wire [1:0] tok_kind_i,
  input wire [3:0] pkt_len_i,
  input wire pkt_ok_i,
  input wire data_toggle_bit_i,
  // Host handshake after our IN data.
  input wire host_ack_i,
  input wire host_noack_i,
  // Answer to the transmitter.
  output reg resp_valid_o,
  output reg [1:0] resp_code_o,
  output reg [3:0] tx_count_o,
  output reg [31:0] tx_data_lo_o,
  output reg [31:0] tx_data_hi_o,
  // Interrupt request pulse.
  output reg irq_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT_ACK = 1'b1;

  wire wr_en;
  wire [5:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [5:0] rd_addr;
  reg [31:0] rd_data;
  wire [7:0] fifo_byte;
  wire fifo_valid;
  wire fifo_ready;

  reg [7:0] mode_r;
  reg [7:0] count_r;
  reg [7:0] buf_r [0:7];
  reg [3:0] idx_r;
  reg st_r;
  reg [3:0] ack_mode_r;

  // Next-state values of the token decision.
  reg hw_upd_nxt;
  reg [3:0] mode_nxt;
  reg [3:0] flag_nxt;
  reg cnt_upd_nxt;
  reg [7:0] count_nxt;
  reg resp_nxt;
  reg [1:0] code_nxt;
  reg irq_nxt;
  reg wait_nxt;
  reg [3:0] amode_nxt;

  wire [3:0] mode = mode_r[`USBC_MODE_MSB:0];
  wire pkt_good = pkt_ok_i && (pkt_len_i <= `USBC_LEN_MAX);
  wire stat_ok = (pkt_len_i == `USBC_LEN_STATUS) && data_toggle_bit_i;
  wire enabled = (mode == `USBC_M_NAK_IO) || (mode == `USBC_M_STAT_OUT) ||
                 (mode == `USBC_M_STALL_IO) || (mode == `USBC_M_STAT_IN) ||
                 (mode == `USBC_M_ACKO_STI) || (mode == `USBC_M_ACKI_STO);
  wire sw_data_wr = wr_en && ((wr_addr == `USBC_OFF_DATA_LO) || (wr_addr == `USBC_OFF_DATA_HI));

  usbc_axil u_bus (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .axi_awaddr_i(axi_awaddr_i),
    .axi_awvalid_i(axi_awvalid_i),
    .axi_awready_o(axi_awready_o),
    .axi_wdata_i(axi_wdata_i),
    .axi_wstrb_i(axi_wstrb_i),
    .axi_wvalid_i(axi_wvalid_i),
    .axi_wready_o(axi_wready_o),
    .axi_bresp_o(axi_bresp_o),
    .axi_bvalid_o(axi_bvalid_o),
    .axi_bready_i(axi_bready_i),
    .axi_araddr_i(axi_araddr_i),
    .axi_arvalid_i(axi_arvalid_i),
    .axi_arready_o(axi_arready_o),
    .axi_rdata_o(axi_rdata_o),
    .axi_rresp_o(axi_rresp_o),
    .axi_rvalid_o(axi_rvalid_o),
    .axi_rready_i(axi_rready_i),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data)
  );

  // Received bytes queue here; the drain stalls while software writes the buffer.
  usbc_fifo #(.W(8), .D(4), .AW(2)) u_rx_fifo (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .in_data_i(rx_byte_i),
    .in_valid_i(rx_valid_i),
    .in_ready_o(rx_ready_o),
    .out_data_o(fifo_byte),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready)
  );
  assign fifo_ready = ~sw_data_wr;

  // Register read mux; reserved bits read as zero.
  always @* begin
    case (rd_addr)
      `USBC_OFF_MODE: rd_data = {24'h000000, mode_r};
      `USBC_OFF_COUNT: rd_data = {24'h000000, count_r};
      `USBC_OFF_DATA_LO: rd_data = {buf_r[3], buf_r[2], buf_r[1], buf_r[0]};
      `USBC_OFF_DATA_HI: rd_data = {buf_r[7], buf_r[6], buf_r[5], buf_r[4]};
      default: rd_data = 32'h00000000;
    endcase
  end

  // Token decision: one table lookup on the mode and the token kind.
  always @* begin
    hw_upd_nxt = 1'b0;
    mode_nxt = mode;
    flag_nxt = 4'h0;
    cnt_upd_nxt = 1'b0;
    count_nxt = {data_toggle_bit_i, 1'b1, 2'h0, pkt_len_i};
    resp_nxt = 1'b0;
    code_nxt = `USBC_R_ACK;
    irq_nxt = 1'b0;
    wait_nxt = 1'b0;
    amode_nxt = mode;
    if (tok_done_i && (st_r == ST_IDLE) && enabled) begin
      case (tok_kind_i)
        `USBC_TOK_SETUP: begin
          if (pkt_good) begin
            resp_nxt = 1'b1;
            hw_upd_nxt = 1'b1;
            mode_nxt = `USBC_M_NAK_IO;
            flag_nxt = 4'h9;
            cnt_upd_nxt = 1'b1;
            irq_nxt = 1'b1;
          end
        end
        `USBC_TOK_IN: begin
          resp_nxt = 1'b1;
          case (mode)
            `USBC_M_NAK_IO: code_nxt = `USBC_R_NAK;
            `USBC_M_STALL_IO: code_nxt = `USBC_R_STALL;
            `USBC_M_STAT_OUT: begin
              code_nxt = `USBC_R_STALL;
              hw_upd_nxt = 1'b1;
              mode_nxt = `USBC_M_STALL_IO;
              irq_nxt = 1'b1;
            end
            `USBC_M_ACKI_STO: begin
              code_nxt = `USBC_R_TX;
              wait_nxt = 1'b1;
              amode_nxt = `USBC_M_NAK_IO;
            end
            default: begin
              code_nxt = `USBC_R_TX;
              wait_nxt = 1'b1;
              amode_nxt = `USBC_M_STALL_IO;
            end
          endcase
        end
        `USBC_TOK_OUT: begin
          if (pkt_good) begin
            resp_nxt = 1'b1;
            case (mode)
              `USBC_M_NAK_IO: code_nxt = `USBC_R_NAK;
              `USBC_M_STALL_IO: code_nxt = `USBC_R_STALL;
              `USBC_M_ACKO_STI: begin
                hw_upd_nxt = 1'b1;
                mode_nxt = `USBC_M_NAK_IO;
                flag_nxt = 4'h3;
                cnt_upd_nxt = 1'b1;
                irq_nxt = 1'b1;
              end
              `USBC_M_STAT_IN: begin
                code_nxt = `USBC_R_STALL;
                hw_upd_nxt = 1'b1;
                mode_nxt = `USBC_M_STALL_IO;
                irq_nxt = 1'b1;
              end
              default: begin
                hw_upd_nxt = 1'b1;
                irq_nxt = 1'b1;
                if (stat_ok) begin
                  mode_nxt = `USBC_M_STAT_OUT;
                  flag_nxt = 4'h3;
                  cnt_upd_nxt = 1'b1;
                  count_nxt = {1'b1, 1'b1, 2'h0, `USBC_LEN_STATUS};
                end else begin
                  code_nxt = `USBC_R_STALL;
                  mode_nxt = `USBC_M_STALL_IO;
                end
              end
            endcase
          end
        end
        default: resp_nxt = 1'b0;
      endcase
    end
  end

  // Wait-for-host-ACK sequencer after IN data; a new token or no-ack abandons it.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r <= ST_IDLE;
      ack_mode_r <= 4'h0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (wait_nxt) begin
            st_r <= ST_WAIT_ACK;
            ack_mode_r <= amode_nxt;
          end
        end
        ST_WAIT_ACK: begin
          if (host_ack_i || host_noack_i || tok_done_i) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Mode register: hardware updates win over a same-cycle firmware write,
  // and hardware-set flags survive a firmware clear in that cycle.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      mode_r <= `USBC_MODE_RST;
    end else begin
      if ((st_r == ST_WAIT_ACK) && host_ack_i) begin
        mode_r[`USBC_MODE_MSB:0] <= ack_mode_r;
        mode_r[`USBC_FLAG_IN] <= 1'b1;
        mode_r[`USBC_FLAG_ACK] <= 1'b1;
        if (wr_en && (wr_addr == `USBC_OFF_MODE) && wr_strb[0]) begin
          mode_r[`USBC_FLAG_SETUP] <= wr_data[`USBC_FLAG_SETUP];
          mode_r[`USBC_FLAG_OUT] <= wr_data[`USBC_FLAG_OUT];
        end
      end else if (hw_upd_nxt) begin
        mode_r[`USBC_MODE_MSB:0] <= mode_nxt;
        mode_r[7:4] <= mode_r[7:4] | flag_nxt;
      end else if (wr_en && (wr_addr == `USBC_OFF_MODE) && wr_strb[0]) begin
        mode_r <= wr_data[7:0];
      end
    end
  end

  // Count register: firmware loads the IN byte count and toggle.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      count_r <= `USBC_COUNT_RST;
    end else if (cnt_upd_nxt) begin
      count_r <= count_nxt;
    end else if (wr_en && (wr_addr == `USBC_OFF_COUNT) && wr_strb[0]) begin
      count_r <= wr_data[7:0];
    end
  end

  // Data buffer: received bytes land in order in enabled modes; beyond eight are dropped.
  // A rejected SETUP or OUT still leaves these bytes behind as junk.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      idx_r <= 4'h0;
    end else if (tok_done_i) begin
      idx_r <= 4'h0;
    end else if (fifo_valid && fifo_ready) begin
      if (idx_r < `USBC_BUF_BYTES) begin
        idx_r <= idx_r + 4'h1;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_buf
      always @(posedge sys_clk_i) begin
        if (reset_i) begin
          buf_r[g] <= 8'h00;
        end else if (sw_data_wr && (wr_addr[2] == (g >= 4)) && wr_strb[g % 4]) begin
          buf_r[g] <= wr_data[(g % 4) * 8 +: 8];
        end else if (fifo_valid && enabled && (idx_r == g)) begin
          buf_r[g] <= fifo_byte;
        end
      end
    end
  endgenerate

  // Answer outputs are registered so the transmitter sees clean pulses.
  always @(posedge sys_clk_i) begin
    if (reset_i) begin
      resp_valid_o <= 1'b0;
      resp_code_o <= `USBC_R_ACK;
      tx_count_o <= 4'h0;
      tx_data_lo_o <= 32'h00000000;
      tx_data_hi_o <= 32'h00000000;
      irq_o <= 1'b0;
    end else begin
      resp_valid_o <= resp_nxt;
      resp_code_o <= code_nxt;
      tx_count_o <= (mode == `USBC_M_ACKI_STO) ? count_r[`USBC_CNT_MSB:0] : 4'h0;
      tx_data_lo_o <= {buf_r[3], buf_r[2], buf_r[1], buf_r[0]};
      tx_data_hi_o <= {buf_r[7], buf_r[6], buf_r[5], buf_r[4]};
      irq_o <= irq_nxt | ((st_r == ST_WAIT_ACK) & host_ack_i);
    end
  end
endmodule

// ---- bench/usbc_ep0_monitor.sv ----
// Port-level checks of the control endpoint responder.
`timescale 1ns/1ps
`include "usbc_defs.vh"
module usbc_ep0_monitor (
  // Clock, reset and token side.
  input wire sys_clk_i,
  input wire reset_i,
  input wire tok_done_i,
  input wire [1:0] tok_kind_i,
  input wire [3:0] pkt_len_i,
  input wire pkt_ok_i,
  input wire host_ack_i,
  input wire host_noack_i,
  // Answers and bus responses.
  input wire resp_valid_o,
  input wire [1:0] resp_code_o,
  input wire irq_o,
  input wire axi_bvalid_o,
  input wire axi_bready_i,
  input wire axi_rvalid_o,
  input wire axi_rready_i
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // A packet is bad when the decoder flags it or it overruns the limit.
  wire bad_pkt = !pkt_ok_i || (pkt_len_i > `USBC_LEN_MAX);
  AST_RESP_CAUSE: assert property (resp_valid_o |-> $past(tok_done_i))
    else $error("Answer without a token.");
  AST_RESP_PULSE: assert property (resp_valid_o |=> !resp_valid_o)
    else $error("Answer held longer than one cycle.");
  AST_SETUP_ACK: assert property (resp_valid_o &&
    $past(tok_kind_i) == `USBC_TOK_SETUP |-> resp_code_o == `USBC_R_ACK)
    else $error("Setup answered other than with ACK.");
  AST_BAD_SETUP: assert property (tok_done_i &&
    tok_kind_i == `USBC_TOK_SETUP && bad_pkt |=> !resp_valid_o && !irq_o)
    else $error("Bad setup was answered.");
  AST_BAD_OUT: assert property (tok_done_i &&
    tok_kind_i == `USBC_TOK_OUT && bad_pkt |=> !resp_valid_o && !irq_o)
    else $error("Bad out packet was answered.");
  AST_NAK_QUIET: assert property (resp_valid_o && resp_code_o == `USBC_R_NAK |-> !irq_o)
    else $error("Interrupt raised with a NAK.");
  AST_TX_IN: assert property (resp_valid_o &&
    resp_code_o == `USBC_R_TX |-> $past(tok_kind_i) == `USBC_TOK_IN)
    else $error("Data sent for a non-IN token.");
  AST_IN_NOT_ACK: assert property (resp_valid_o &&
    $past(tok_kind_i) == `USBC_TOK_IN |-> resp_code_o != `USBC_R_ACK)
    else $error("IN token answered with ACK.");
  AST_IRQ_CAUSE: assert property (irq_o |-> $past(tok_done_i) || $past(host_ack_i))
    else $error("Interrupt without a cause.");
  AST_NOACK: assert property (host_noack_i |=> !irq_o && !resp_valid_o)
    else $error("Missing host ACK changed something.");
  AST_B_ONE: assert property (axi_bvalid_o && axi_bready_i |=> !axi_bvalid_o)
    else $error("Write response repeated.");
  AST_R_ONE: assert property (axi_rvalid_o && axi_rready_i |=> !axi_rvalid_o)
    else $error("Read response repeated.");
endmodule

// ---- bench/usbc_host_model.sv ----
// Behavioural host and packet decoder feeding the responder.
`timescale 1ns/1ps
module usbc_host_model (
  // Clock and byte stream.
  input wire sys_clk_i,
  output logic [7:0] rx_byte_o = 8'h00,
  output logic rx_valid_o = 1'b0,
  input wire rx_ready_i,
  // Token strobes and host handshake.
  output logic tok_done_o = 1'b0,
  output logic [1:0] tok_kind_o = 2'h3,
  output logic [3:0] pkt_len_o = 4'h0,
  output logic pkt_ok_o = 1'b0,
  output logic data_toggle_bit_o = 1'b0,
  output logic host_ack_o = 1'b0,
  output logic host_noack_o = 1'b0
);
  // Bytes wait for ready; a released line shows the inverse to hide stale data.
  task send_bytes(input int n, input logic [7:0] base);
    int i;
    @(posedge sys_clk_i);
    rx_byte_o <= base;
    rx_valid_o <= 1'b1;
    for (i = 1; i <= n; i++) begin
      do @(posedge sys_clk_i); while (rx_ready_i !== 1'b1);
      rx_byte_o <= (i == n) ? ~(base + 8'(i - 1)) : base + 8'(i);
      rx_valid_o <= (i != n);
    end
  endtask
  // Status stages use IN or OUT tokens; length counts data plus two CRC bytes.
  task token(input logic [1:0] k, input logic [3:0] len, input logic ok, input logic tog);
    @(posedge sys_clk_i);
    tok_done_o <= 1'b1;
    tok_kind_o <= k;
    pkt_len_o <= len;
    pkt_ok_o <= ok;
    data_toggle_bit_o <= tog;
    @(posedge sys_clk_i);
    tok_done_o <= 1'b0;
    tok_kind_o <= ~k;
    pkt_len_o <= ~len;
    pkt_ok_o <= ~ok;
    data_toggle_bit_o <= ~tog;
  endtask
  // One-cycle host handshake after IN data.
  task answer(input logic ack);
    @(posedge sys_clk_i);
    host_ack_o <= ack;
    host_noack_o <= !ack;
    @(posedge sys_clk_i);
    host_ack_o <= 1'b0;
    host_noack_o <= 1'b0;
  endtask
endmodule

// ---- bench/usbc_ep0_responder_tb_top.sv ----
// Self-checking bench for the control endpoint responder.
`timescale 1ns/1ps
`include "usbc_defs.vh"
module usbc_ep0_responder_tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, rx_valid, rx_ready, tok_done, pkt_ok;
  wire tog_bit, h_ack, h_nack, resp_valid, irq;
  wire [1:0] bresp, rresp, tok_kind, resp_code;
  wire [31:0] rdata, tx_lo, tx_hi;
  wire [7:0] rx_byte;
  wire [3:0] pkt_len, tx_count;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] rd_q, resp_q;
  // Free-running 125 MHz clock.
  always #4 sys_clk_i = ~sys_clk_i;
  usbc_ep0_responder dut_u (.sys_clk_i, .reset_i, .axi_awaddr_i(awaddr), .axi_awvalid_i(awvalid),
    .axi_awready_o(awready), .axi_wdata_i(wdata), .axi_wstrb_i(wstrb), .axi_wvalid_i(wvalid),
    .axi_wready_o(wready), .axi_bresp_o(bresp), .axi_bvalid_o(bvalid), .axi_bready_i(bready),
    .axi_araddr_i(araddr), .axi_arvalid_i(arvalid), .axi_arready_o(arready),
    .axi_rdata_o(rdata), .axi_rresp_o(rresp), .axi_rvalid_o(rvalid), .axi_rready_i(rready),
    .rx_byte_i(rx_byte), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready), .tok_done_i(tok_done),
    .tok_kind_i(tok_kind), .pkt_len_i(pkt_len), .pkt_ok_i(pkt_ok), .data_toggle_bit_i(tog_bit),
    .host_ack_i(h_ack), .host_noack_i(h_nack), .resp_valid_o(resp_valid),
    .resp_code_o(resp_code), .tx_count_o(tx_count), .tx_data_lo_o(tx_lo),
    .tx_data_hi_o(tx_hi), .irq_o(irq));
  usbc_host_model host_u (.sys_clk_i, .rx_byte_o(rx_byte), .rx_valid_o(rx_valid),
    .rx_ready_i(rx_ready), .tok_done_o(tok_done), .tok_kind_o(tok_kind), .pkt_len_o(pkt_len),
    .pkt_ok_o(pkt_ok), .data_toggle_bit_o(tog_bit), .host_ack_o(h_ack), .host_noack_o(h_nack));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Write with both channels offered together; bready held until bvalid.
  task wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_p, w_p;
    @(posedge sys_clk_i);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (aw_p && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp_q = {30'h0, bresp};
  endtask
  // Read and compare one register word.
  task rchk(input logic [5:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_q = rdata;
    resp_q = {30'h0, rresp};
    chk(rd_q, exp);
  endtask
  // Token, then the answer and interrupt one cycle later.
  task tk(input logic [1:0] k, input logic [3:0] len, input logic ok, input logic tog,
    input logic ev, input logic [1:0] ec, input logic ei);
    host_u.token(k, len, ok, tog);
    #1;
    chk({31'h0, resp_valid}, {31'h0, ev});
    if (ev)
      chk({30'h0, resp_code}, {30'h0, ec});
    chk({31'h0, irq}, {31'h0, ei});
  endtask
  task s_regs;
    int k;
    rchk(`USBC_OFF_MODE, 32'h0);
    rchk(`USBC_OFF_COUNT, 32'h0);
    rchk(6'h10, 32'h0);
    chk(resp_q, 32'h2);
    wr(6'h10, 32'hFF);
    chk(resp_q, 32'h2);
    for (k = 0; k < 3; k++)
      tk(k[1:0], 4'h4, 1'b1, 1'b1, 1'b0, 2'h0, 1'b0);
  endtask
  task s_stall_all;
    wr(`USBC_OFF_MODE, 32'h3);
    tk(`USBC_TOK_IN, 4'h0, 1'b1, 1'b0, 1'b1, `USBC_R_STALL, 1'b0);
    tk(`USBC_TOK_OUT, 4'h4, 1'b1, 1'b0, 1'b1, `USBC_R_STALL, 1'b0);
    tk(`USBC_TOK_OUT, 4'hB, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0);
    tk(`USBC_TOK_OUT, 4'h4, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
    tk(`USBC_TOK_SETUP, 4'hB, 1'b1, 1'b0, 1'b0, 2'h0, 1'b0);
    tk(`USBC_TOK_SETUP, 4'h4, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0);
    rchk(`USBC_OFF_MODE, 32'h03);
    host_u.send_bytes(8, 8'h10);
    repeat (8) @(posedge sys_clk_i);
    tk(`USBC_TOK_SETUP, 4'hA, 1'b1, 1'b1, 1'b1, `USBC_R_ACK, 1'b1);
    rchk(`USBC_OFF_MODE, 32'h91);
    rchk(`USBC_OFF_COUNT, 32'hCA);
    rchk(`USBC_OFF_DATA_LO, 32'h13121110);
    rchk(`USBC_OFF_DATA_HI, 32'h17161514);
    chk(tx_lo, 32'h13121110);
    chk(tx_hi, 32'h17161514);
  endtask
  // Every enabled control mode accepts a good setup the same way.
  task s_modes;
    int i;
    logic [23:0] ml;
    ml = 24'hFB6321;
    for (i = 0; i < 6; i++) begin
      wr(`USBC_OFF_MODE, {28'h0, ml[i*4 +: 4]});
      tk(`USBC_TOK_SETUP, 4'h4, 1'b1, 1'b0, 1'b1, `USBC_R_ACK, 1'b1);
      rchk(`USBC_OFF_MODE, 32'h91);
    end
  endtask
  task s_nak;
    wr(`USBC_OFF_MODE, 32'h1);
    tk(`USBC_TOK_IN, 4'h0, 1'b1, 1'b0, 1'b1, `USBC_R_NAK, 1'b0);
    tk(`USBC_TOK_OUT, 4'h4, 1'b1, 1'b1, 1'b1, `USBC_R_NAK, 1'b0);
    rchk(`USBC_OFF_MODE, 32'h01);
  endtask
  task s_ack_in;
    wr(`USBC_OFF_COUNT, 32'h5);
    wr(`USBC_OFF_MODE, 32'hF);
    tk(`USBC_TOK_IN, 4'h0, 1'b1, 1'b0, 1'b1, `USBC_R_TX, 1'b0);
    chk({28'h0, tx_count}, 32'h5);
    host_u.answer(1'b0);
    rchk(`USBC_OFF_MODE, 32'h0F);
    tk(`USBC_TOK_IN, 4'h0, 1'b1, 1'b0, 1'b1, `USBC_R_TX, 1'b0);
    host_u.answer(1'b1);
    #1;
    chk({31'h0, irq}, 32'h1);
    rchk(`USBC_OFF_MODE, 32'h51);
  endtask
  // Status stage: good zero-data OUT, IN in status-out mode, then bad-length and toggle-0 OUT.
  task s_status;
    wr(`USBC_OFF_MODE, 32'hF);
    tk(`USBC_TOK_OUT, 4'h2, 1'b1, 1'b1, 1'b1, `USBC_R_ACK, 1'b1);
    rchk(`USBC_OFF_MODE, 32'h32);
    rchk(`USBC_OFF_COUNT, 32'hC2);
    tk(`USBC_TOK_OUT, 4'h2, 1'b1, 1'b1, 1'b1, `USBC_R_ACK, 1'b1);
    tk(`USBC_TOK_IN, 4'h0, 1'b1, 1'b0, 1'b1, `USBC_R_STALL, 1'b1);
    rchk(`USBC_OFF_MODE, 32'h33);
    wr(`USBC_OFF_MODE, 32'hF);
    tk(`USBC_TOK_OUT, 4'h3, 1'b1, 1'b1, 1'b1, `USBC_R_STALL, 1'b1);
    rchk(`USBC_OFF_MODE, 32'h03);
    wr(`USBC_OFF_MODE, 32'hF);
    tk(`USBC_TOK_OUT, 4'h2, 1'b1, 1'b0, 1'b1, `USBC_R_STALL, 1'b1);
    rchk(`USBC_OFF_MODE, 32'h03);
  endtask
  // Main sequence after a twelve-cycle reset.
  initial begin
    repeat (12) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    s_regs;
    s_stall_all;
    s_modes;
    s_nak;
    s_ack_in;
    s_status;
    end_sim;
  end
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    n_errors++;
    end_sim;
  end
endmodule
bind usbc_ep0_responder usbc_ep0_monitor mon_u (.sys_clk_i, .reset_i, .tok_done_i, .tok_kind_i,
  .pkt_len_i, .pkt_ok_i, .host_ack_i, .host_noack_i, .resp_valid_o, .resp_code_o, .irq_o,
  .axi_bvalid_o, .axi_bready_i, .axi_rvalid_o, .axi_rready_i);
